// File: alarm_annunciator.sv
// Four-channel alarm annunciator: warnings, normal lamp, bell, relays
// What this block does
// - Warning output per channel stays on while that channel is faulted.
// - Normal output on while no channel faulted, off on any fault.
// - Bell rings when any channel faulted, unless silenced.
// - Bell goes off once all channels are back to normal.
// - Silence press while ringing stops bell until a further warning.
// - Each channel drives its own aux relay, energized while that channel is faulted.
// - Aux relays ignore silence and test and follow only their channel fault.
// - Test held with all normal lights all warnings and the bell.
// - Normal output goes off while test is held.
// - Test release with no faults restores normal, clears warnings and bell.
// - Silence during test stops bell but warnings stay on.
// - Inverse mode: open sensor is normal, shorted sensor is fault.
// - Direct mode: open sensor is fault, shorted sensor is normal.
// - Each channel has its own polarity mode input.
// - System-fault changeover in alarm state until silence or warning clears.
`timescale 1ns/1ps
module alarm_annunciator
  import alarm_pkg::*;
#(
  parameter int unsigned CHANNELS   = NUM_CH,
  parameter int unsigned SETTLE_CYC = DEBOUNCE_CYC
) (
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire logic [CHANNELS-1:0] sensor_shorted,
  input  wire logic [CHANNELS-1:0] inverse_mode,
  input  wire logic                test_button,
  input  wire logic                silence_button,
  output logic      [CHANNELS-1:0] warning_out,
  output logic                     normal_out,
  output logic                     bell_out,
  output logic      [CHANNELS-1:0] aux_relay_on,
  output logic                     sys_fault_alarm
);
  logic [CHANNELS-1:0] shorted_c;
  logic                test_c;
  logic                silence_c;

  // Sensors settle before use; unknown at reset counts as open circuit
  for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
    input_conditioner #(
      .SETTLE_CYC (SETTLE_CYC)
    ) u_sense (
      .clk       (clk),
      .arst_n    (arst_n),
      .raw_in    (sensor_shorted[i]),
      .rst_val   (1'b0),
      .clean_out (shorted_c[i])
    );
  end

  input_conditioner #(
    .SETTLE_CYC (SETTLE_CYC)
  ) u_test (
    .clk       (clk),
    .arst_n    (arst_n),
    .raw_in    (test_button),
    .rst_val   (1'b0),
    .clean_out (test_c)
  );

  input_conditioner #(
    .SETTLE_CYC (SETTLE_CYC)
  ) u_silence (
    .clk       (clk),
    .arst_n    (arst_n),
    .raw_in    (silence_button),
    .rst_val   (1'b0),
    .clean_out (silence_c)
  );

  function automatic logic [CHANNELS-1:0] decode_fault(
    input logic [CHANNELS-1:0] shorted,
    input logic [CHANNELS-1:0] inverse
  );
    // Inverse: short means fault; direct: open means fault
    decode_fault = ~(shorted ^ inverse);
  endfunction

  localparam int unsigned WARM_CYC = SYNC_STAGES + SETTLE_CYC;
  localparam int unsigned WW       = $clog2(WARM_CYC + 1);

  logic [CHANNELS-1:0] fault;
  logic                any_fault;
  logic                test_live;
  logic                test_active;
  logic [WW-1:0]       warm_q;
  logic [WW-1:0]       warm_d;
  logic                warm_done;

  // Outputs rest until every conditioner has seen its pin once
  always_comb begin
    warm_done = (warm_q == WW'(WARM_CYC));
    warm_d    = warm_q;
    if (!warm_done) begin
      warm_d = warm_q + WW'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      warm_q <= '0;
    end else begin
      warm_q <= warm_d;
    end
  end

  assign fault       = warm_done ? decode_fault(shorted_c, inverse_mode) : '0;
  assign any_fault   = |fault;
  assign test_live   = warm_done && test_c;
  assign test_active = test_live && !any_fault;

  bell_state_t         bell_q;
  bell_state_t         bell_d;
  logic [CHANNELS-1:0] fault_q;
  logic [CHANNELS-1:0] fault_d;
  logic                test_q;
  logic                test_d;
  logic [CHANNELS-1:0] warn_q;
  logic [CHANNELS-1:0] warn_d;
  logic [CHANNELS-1:0] aux_q;
  logic [CHANNELS-1:0] aux_d;
  logic                normal_q;
  logic                normal_d;
  logic                bell_out_q;
  logic                bell_out_d;
  logic                sysf_q;
  logic                sysf_d;
  logic                alarm_cause;
  logic                new_cause;

  // Last cycle's causes, for the re-arm edge
  always_comb begin
    fault_d = fault;
    test_d  = test_active;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_q <= '0;
      test_q  <= 1'b0;
    end else begin
      fault_q <= fault_d;
      test_q  <= test_d;
    end
  end

  // Bell: idle, ringing or silenced
  always_comb begin
    alarm_cause = any_fault || test_active;
    // A channel newly faulted, or a fresh test press, re-arms the bell
    new_cause   = (|(fault & ~fault_q)) || (test_active && !test_q);
    bell_d      = bell_q;
    case (bell_q)
      BELL_IDLE: begin
        if (alarm_cause) begin
          bell_d = BELL_RINGING;
        end
      end
      BELL_RINGING: begin
        if (!alarm_cause) begin
          bell_d = BELL_IDLE;
        end else if (silence_c && !new_cause) begin
          bell_d = BELL_SILENCED;
        end
      end
      BELL_SILENCED: begin
        if (!alarm_cause) begin
          bell_d = BELL_IDLE;
        end else if (new_cause) begin
          bell_d = BELL_RINGING;
        end
      end
      default: begin
        bell_d = BELL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bell_q <= BELL_IDLE;
    end else begin
      bell_q <= bell_d;
    end
  end

  // Lamps and contacts registered so they never glitch
  always_comb begin
    warn_d     = test_active ? {CHANNELS{1'b1}} : fault;
    aux_d      = fault;
    normal_d   = !any_fault && !test_live;
    bell_out_d = (bell_d == BELL_RINGING);
    sysf_d     = (bell_d == BELL_RINGING) && any_fault;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      warn_q     <= '0;
      aux_q      <= '0;
      normal_q   <= NORMAL_RST;
      bell_out_q <= OUT_RST;
      sysf_q     <= OUT_RST;
    end else begin
      warn_q     <= warn_d;
      aux_q      <= aux_d;
      normal_q   <= normal_d;
      bell_out_q <= bell_out_d;
      sysf_q     <= sysf_d;
    end
  end

  assign warning_out     = warn_q;
  assign aux_relay_on    = aux_q;
  assign normal_out      = normal_q;
  assign bell_out        = bell_out_q;
  assign sys_fault_alarm = sysf_q;
endmodule

// File: alarm_pkg.sv
// Shared constants for the four-channel alarm annunciator
package alarm_pkg;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned NUM_CH        = 4;
  localparam int unsigned DEBOUNCE_MS   = 20;
  localparam int unsigned DEBOUNCE_CYC  = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int unsigned SYNC_STAGES   = 3;
  localparam logic        OUT_RST       = 1'b0;
  localparam logic        NORMAL_RST    = 1'b1;

  typedef enum logic [1:0] {
    BELL_IDLE     = 2'b00,
    BELL_RINGING  = 2'b01,
    BELL_SILENCED = 2'b10
  } bell_state_t;
endpackage

// File: input_conditioner.sv
// Three-stage synchroniser with a settle-time debounce for one input
`timescale 1ns/1ps
module input_conditioner
  import alarm_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = DEBOUNCE_CYC
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic raw_in,
  input  wire logic rst_val,
  output logic      clean_out
);
  localparam int unsigned CW = $clog2(SETTLE_CYC + 1);

  logic [2:0]    sync_q;
  logic [2:0]    sync_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          out_q;
  logic          out_d;
  logic          init_q;
  logic          init_d;

  always_comb begin
    sync_d = {sync_q[1:0], raw_in};
    cnt_d  = cnt_q;
    out_d  = out_q;
    init_d = 1'b1;
    if (!init_q) begin
      out_d = rst_val;
    end else if (sync_q[1] != sync_q[2] || sync_q[2] == out_q) begin
      // Only a stable, differing level advances the settle count
      cnt_d = '0;
    end else if (cnt_q >= CW'(SETTLE_CYC - 1)) begin
      cnt_d = '0;
      out_d = sync_q[2];
    end else begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_q <= 3'h0;
      cnt_q  <= '0;
      out_q  <= 1'b0;
      init_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      cnt_q  <= cnt_d;
      out_q  <= out_d;
      init_q <= init_d;
    end
  end

  assign clean_out = out_q;
endmodule

// File: alarm_checker_properties.sv
// Output relation checker for the alarm annunciator
`timescale 1ns/1ps
module alarm_checker #(
  parameter int unsigned CHANNELS = 4
) (
  input wire logic                clk,
  input wire logic                arst_n,
  input wire logic [CHANNELS-1:0] warning_out,
  input wire logic                normal_out,
  input wire logic                bell_out,
  input wire logic [CHANNELS-1:0] aux_relay_on,
  input wire logic                sys_fault_alarm
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  normal_quiet_a: assert property (normal_out |-> warning_out == '0 && !bell_out)
    else $error("normal lamp lit beside warning or bell");
  normal_drop_a: assert property ($fell(normal_out) |-> warning_out != '0)
    else $error("normal lamp dropped without warnings");
  bell_cause_a: assert property (bell_out |-> !normal_out && warning_out != '0)
    else $error("bell on without any warning");
  aux_follow_a: assert property (aux_relay_on != '0 |-> aux_relay_on == warning_out)
    else $error("aux relay differs from warning");
  fault_bell_a: assert property (sys_fault_alarm |-> bell_out && aux_relay_on != '0)
    else $error("system fault without ringing fault");
  bell_fault_a: assert property (bell_out && aux_relay_on != '0 |-> sys_fault_alarm)
    else $error("ringing fault without system fault");
  silence_keep_a: assert property ($fell(bell_out) && warning_out != '0 |-> $stable(warning_out))
    else $error("warnings changed when bell silenced");
  aux_silent_a: assert property ($fell(bell_out) && aux_relay_on != '0 |-> $stable(aux_relay_on))
    else $error("aux relay moved with silence");
  test_lamp_a: assert property (warning_out == '1 && aux_relay_on == '0 |-> !sys_fault_alarm)
    else $error("system fault during lamp test");
endmodule

// File: field_side.sv
// Field side model: sensor loops and momentary pushbuttons
`timescale 1ns/1ps
module field_side (
  input  wire logic [3:0] fault,
  input  wire logic [3:0] inverse,
  input  wire logic       press_test,
  input  wire logic       press_sil,
  output logic      [3:0] sensor_shorted,
  output logic            test_button,
  output logic            silence_button
);
  // Loop shorted on fault in inverse mode, open on fault in direct mode
  assign sensor_shorted = ~(fault ^ inverse);
  assign test_button    = press_test;
  assign silence_button = press_sil;
endmodule

// File: testbench.sv
// Self-checking bench for the alarm annunciator
`timescale 1ns/1ps
module testbench;
  logic       clk = 0, arst_n = 0, tst = 0, sil = 0, tb, sb, norm, bell, sysf;
  logic [3:0] flt = 4'h0, inv, shorted, warn, aux, f;
  int         error_cnt = 0, checks_done = 0, silenced = 0;
  always #50 clk = ~clk;
  field_side fs (.fault(flt), .inverse(inv), .press_test(tst), .press_sil(sil),
    .sensor_shorted(shorted), .test_button(tb), .silence_button(sb));
  alarm_annunciator #(.CHANNELS(4), .SETTLE_CYC(4)) uut (.clk(clk), .arst_n(arst_n),
    .sensor_shorted(shorted), .inverse_mode(inv), .test_button(tb), .silence_button(sb),
    .warning_out(warn), .normal_out(norm), .bell_out(bell), .aux_relay_on(aux),
    .sys_fault_alarm(sysf));
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Drive one level set, let it settle, compare with the model
  task automatic step(input logic [3:0] nf, input logic t, input logic s);
    logic        ring;
    logic [3:0]  lamps;
    logic [10:0] want;
    @(posedge clk);
    if ((nf & ~flt) != 4'h0 || (t && !tst)) silenced = 0;
    flt <= nf;
    tst <= t;
    sil <= s;
    repeat (14) @(posedge clk);
    if (s && (nf != 4'h0 || t)) silenced = 1;
    if (nf == 4'h0 && !t) silenced = 0;
    ring  = (nf != 4'h0 || t) && silenced == 0;
    lamps = (nf != 4'h0) ? nf : (t ? 4'hF : 4'h0);
    want  = {lamps, nf, nf == 4'h0 && !t, ring, ring && nf != 4'h0};
    check({warn, aux, norm, bell, sysf}, want);
  endtask
  initial begin
    inv <= 4'($urandom(54923));
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    step(4'h0, 0, 0);
    step(4'h1, 0, 0);
    step(4'h1, 0, 1);
    step(4'h1, 0, 0);
    step(4'h3, 0, 0);
    step(4'h3, 0, 1);
    step(4'h0, 0, 0);
    step(4'h0, 1, 0);
    step(4'h0, 1, 1);
    step(4'h0, 1, 0);
    step(4'h0, 0, 0);
    for (int i = 0; i < 20; i++) begin
      f = 4'($urandom);
      step(f, 0, 0);
      step(f, 0, 1);
      step(f, 0, 0);
    end
    stop_test();
  end
  initial begin
    #500000;
    error_cnt++;
    stop_test();
  end
endmodule
bind alarm_annunciator alarm_checker #(.CHANNELS(CHANNELS)) chk (.clk(clk), .arst_n(arst_n),
  .warning_out(warning_out), .normal_out(normal_out), .bell_out(bell_out),
  .aux_relay_on(aux_relay_on), .sys_fault_alarm(sys_fault_alarm));
